// ### cct_defines.svh
// offsets, field positions, reset values and counts of the capture/compare timer
`ifndef CCT_DEFINES_SVH
`define CCT_DEFINES_SVH
`define CCT_ADDR_CTRL1 4'h0
`define CCT_ADDR_CTRL2 4'h1
`define CCT_ADDR_STATUS 4'h2
`define CCT_ADDR_CMP1_HI 4'h3
`define CCT_ADDR_CMP1_LO 4'h4
`define CCT_ADDR_CMP2_HI 4'h5
`define CCT_ADDR_CMP2_LO 4'h6
`define CCT_ADDR_CAP1_HI 4'h7
`define CCT_ADDR_CAP1_LO 4'h8
`define CCT_ADDR_CAP2_HI 4'h9
`define CCT_ADDR_CAP2_LO 4'hA
`define CCT_ADDR_CNT_HI 4'hB
`define CCT_ADDR_CNT_LO 4'hC
`define CCT_C1_CAP_IE 7
`define CCT_C1_CMP_IE 6
`define CCT_C1_OVF_IE 5
`define CCT_C1_FORCE2 4
`define CCT_C1_FORCE1 3
`define CCT_C1_LEVEL2 2
`define CCT_C1_EDGE1 1
`define CCT_C1_LEVEL1 0
`define CCT_C2_PIN1_EN 7
`define CCT_C2_PIN2_EN 6
`define CCT_C2_ONE_PULSE 5
`define CCT_C2_PWM 4
`define CCT_C2_CLK_HI 3
`define CCT_C2_CLK_LO 2
`define CCT_C2_EDGE2 1
`define CCT_C2_EXT_EDGE 0
`define CCT_ST_CAP1 7
`define CCT_ST_CMP1 6
`define CCT_ST_OVF 5
`define CCT_ST_CAP2 4
`define CCT_ST_CMP2 3
`define CCT_CTRL_RESET 8'h00
`define CCT_CNT_RESET 16'hFFFC
`define CCT_CMP_RESET 16'h8000
`define CCT_DIV2 4'h1
`define CCT_DIV4 4'h3
`define CCT_DIV8 4'h7
`endif

// ### cct_pkg.sv
// types of the capture/compare timer
package cct_pkg;
   typedef enum logic [1:0] {
      CCT_CLK_DIV4 = 2'h0,
      CCT_CLK_DIV2 = 2'h1,
      CCT_CLK_DIV8 = 2'h2,
      CCT_CLK_EXT = 2'h3
   } cct_clk_e;
   typedef enum logic [2:0] {
      CCT_RUN = 3'h1,
      CCT_HALT = 3'h2,
      CCT_WAKE = 3'h4
   } cct_pwr_e;
endpackage

// ### cct_edge_detect.sv
// edge detector with selectable polarity for synchronous pins
`timescale 1ns/100ps
`default_nettype none
module cct_edge_detect (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic pin,
   input wire logic rising,
   output logic hit
);
   logic last;
   logic primed;
   // the first sample after reset only loads last, so a pin resting high gives no false edge
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         last <= 1'b0;
         primed <= 1'b0;
      end else begin
         last <= pin;
         primed <= 1'b1;
      end
   end
   // zero selects falling, one selects rising
   assign hit = primed & (rising ? (pin & ~last) : (~pin & last));
endmodule // cct_edge_detect
`default_nettype wire

// ### cct_timer.sv
// capture/compare timer: control registers, counter, captures, compares, modes, interrupt
`timescale 1ns/100ps
`default_nettype none
`include "cct_defines.svh"
module cct_timer #(
   parameter bit HAS_EXT_PIN = 1'b1
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   input wire logic haltMode,
   input wire logic globalIrqMask,
   input wire logic captureOneInput,
   input wire logic captureTwoInput,
   input wire logic externalCountClockPin,
   output logic timerIrq,
   output logic compareOnePin,
   output logic compareOnePinEnable,
   output logic compareTwoPin,
   output logic compareTwoPinEnable
);
   logic [7:0] timerControlOne;
   logic [7:0] timerControlTwo;
   logic [15:0] counter;
   logic [15:0] compareOneValue;
   logic [15:0] compareTwoValue;
   logic [15:0] captureOneValue;
   logic [15:0] captureTwoValue;
   logic [7:0] cmp1HiHold;
   logic [7:0] cmp2HiHold;
   logic captureOneFlag, captureTwoFlag, compareOneFlag, compareTwoFlag, overflowFlag;
   logic [3:0] prescale;
   logic statusSeen;
   logic armOne, armTwo;
   cct_pkg::cct_pwr_e pwrState;
   logic edgeOne, edgeTwo, edgeExt;
   logic tick, pwmMode, onePulseMode, running, wakeNow;
   logic matchOne, matchTwo, overflowNow;
   logic capOneEvt, capTwoEvt;
   logic next_irq;
   cct_pkg::cct_clk_e clkSel;

   // bus side strobes, one cycle each
   wire wrCtrl1 = regWrite && regAddr == `CCT_ADDR_CTRL1;
   wire wrCtrl2 = regWrite && regAddr == `CCT_ADDR_CTRL2;
   wire rdStatus = regRead && regAddr == `CCT_ADDR_STATUS;
   wire accCnt = (regRead || regWrite) && regAddr == `CCT_ADDR_CNT_LO;
   wire accCap1 = regRead && regAddr == `CCT_ADDR_CAP1_LO;
   wire accCap2 = regRead && regAddr == `CCT_ADDR_CAP2_LO;
   wire accCmp1 = (regRead || regWrite) && regAddr == `CCT_ADDR_CMP1_LO;
   wire accCmp2 = (regRead || regWrite) && regAddr == `CCT_ADDR_CMP2_LO;

   assign clkSel = cct_pkg::cct_clk_e'(timerControlTwo[`CCT_C2_CLK_HI:`CCT_C2_CLK_LO]);
   assign pwmMode = timerControlTwo[`CCT_C2_PWM];
   assign onePulseMode = timerControlTwo[`CCT_C2_ONE_PULSE] & ~pwmMode;
   assign running = pwrState == cct_pkg::CCT_RUN;
   assign wakeNow = pwrState == cct_pkg::CCT_WAKE;

   cct_edge_detect u_edge_one (
      .mclk(mclk),
      .reset_n(reset_n),
      .pin(captureOneInput),
      .rising(timerControlOne[`CCT_C1_EDGE1]),
      .hit(edgeOne)
   );
   cct_edge_detect u_edge_two (
      .mclk(mclk),
      .reset_n(reset_n),
      .pin(captureTwoInput),
      .rising(timerControlTwo[`CCT_C2_EDGE2]),
      .hit(edgeTwo)
   );
   cct_edge_detect u_edge_ext (
      .mclk(mclk),
      .reset_n(reset_n),
      .pin(externalCountClockPin),
      .rising(timerControlTwo[`CCT_C2_EXT_EDGE]),
      .hit(edgeExt)
   );

   function automatic logic divDone(input logic [3:0] cnt, input cct_pkg::cct_clk_e sel);
      unique case (sel)
         cct_pkg::CCT_CLK_DIV2: divDone = cnt[0] == 1'(`CCT_DIV2);
         cct_pkg::CCT_CLK_DIV4: divDone = cnt[1:0] == 2'(`CCT_DIV4);
         cct_pkg::CCT_CLK_DIV8: divDone = cnt[2:0] == 3'(`CCT_DIV8);
         cct_pkg::CCT_CLK_EXT: divDone = 1'b0;
      endcase
   endfunction

   // counter tick; external needs a pin, else counting stops
   always_comb begin
      if (clkSel == cct_pkg::CCT_CLK_EXT) begin
         tick = HAS_EXT_PIN && edgeExt && running;
      end else begin
         tick = running && divDone(prescale, clkSel);
      end
   end

   // halt freezes the prescaler too, so no tick sneaks out on wake
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prescale <= 4'h0;
      end else if (running) begin
         prescale <= prescale + 4'h1;
      end
   end

   // wait is not an input at all: the timer runs straight through it
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pwrState <= cct_pkg::CCT_RUN;
      end else begin
         unique case (pwrState)
            cct_pkg::CCT_RUN: if (haltMode) begin
               pwrState <= cct_pkg::CCT_HALT;
            end
            cct_pkg::CCT_HALT: if (!haltMode) begin
               pwrState <= cct_pkg::CCT_WAKE;
            end
            cct_pkg::CCT_WAKE: begin
               pwrState <= haltMode ? cct_pkg::CCT_HALT : cct_pkg::CCT_RUN;
            end
         endcase
      end
   end

   // edges seen while halted are remembered until wake
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         armOne <= 1'b0;
         armTwo <= 1'b0;
      end else if (wakeNow) begin
         armOne <= 1'b0;
         armTwo <= 1'b0;
      end else if (pwrState == cct_pkg::CCT_HALT) begin
         armOne <= armOne | edgeOne;
         armTwo <= armTwo | edgeTwo;
      end
   end

   assign matchOne = tick && counter == compareOneValue;
   assign matchTwo = tick && counter == compareTwoValue;
   assign overflowNow = tick && counter == 16'hFFFF;
   // capture one is disconnected in pulse-width mode
   assign capOneEvt = !pwmMode && ((running && edgeOne) || (wakeNow && armOne));
   assign capTwoEvt = (running && edgeTwo) || (wakeNow && armTwo);

   // counter holds in halt; reset restarts from reset value
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         counter <= `CCT_CNT_RESET;
      end else if (regWrite && regAddr == `CCT_ADDR_CNT_LO) begin
         counter <= `CCT_CNT_RESET;
      end else if (onePulseMode && running && edgeOne) begin
         counter <= `CCT_CNT_RESET;
      end else if (pwmMode && matchTwo) begin
         counter <= `CCT_CNT_RESET;
      end else if (tick) begin
         counter <= counter + 16'h0001;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         timerControlOne <= `CCT_CTRL_RESET;
         timerControlTwo <= `CCT_CTRL_RESET;
      end else begin
         if (wrCtrl1) begin
            timerControlOne <= regWdata;
         end
         if (wrCtrl2) begin
            timerControlTwo <= regWdata;
         end
      end
   end

   // compare values: high byte held until low byte written
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         compareOneValue <= `CCT_CMP_RESET;
         compareTwoValue <= `CCT_CMP_RESET;
         cmp1HiHold <= 8'h80;
         cmp2HiHold <= 8'h80;
      end else begin
         if (regWrite && regAddr == `CCT_ADDR_CMP1_HI) begin
            cmp1HiHold <= regWdata;
         end
         if (regWrite && regAddr == `CCT_ADDR_CMP2_HI) begin
            cmp2HiHold <= regWdata;
         end
         if (regWrite && regAddr == `CCT_ADDR_CMP1_LO) begin
            compareOneValue <= {cmp1HiHold, regWdata};
         end
         if (regWrite && regAddr == `CCT_ADDR_CMP2_LO) begin
            compareTwoValue <= {cmp2HiHold, regWdata};
         end
      end
   end

   // capture registers; one-pulse mode loads capture one with the reset value plus one, pulse-width mode never loads it
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         captureOneValue <= 16'h0000;
         captureTwoValue <= 16'h0000;
      end else begin
         if (capOneEvt) begin
            captureOneValue <= onePulseMode ? `CCT_CNT_RESET + 16'h0001 : counter;
         end
         if (capTwoEvt) begin
            captureTwoValue <= counter;
         end
      end
   end

   // a flag clears on a status read followed by its data access; set wins
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         statusSeen <= 1'b0;
      end else if (rdStatus) begin
         statusSeen <= 1'b1;
      end else if (accCnt || accCap1 || accCap2 || accCmp1 || accCmp2) begin
         statusSeen <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         captureOneFlag <= 1'b0;
         captureTwoFlag <= 1'b0;
         compareOneFlag <= 1'b0;
         compareTwoFlag <= 1'b0;
         overflowFlag <= 1'b0;
      end else begin
         // pulse-width wrap reports through capture one
         if (capOneEvt || (pwmMode && matchTwo)) begin
            captureOneFlag <= 1'b1;
         end else if (statusSeen && accCap1) begin
            captureOneFlag <= 1'b0;
         end
         if (capTwoEvt) begin
            captureTwoFlag <= 1'b1;
         end else if (statusSeen && accCap2) begin
            captureTwoFlag <= 1'b0;
         end
         // compare runs whatever the pin enable; no events in pulse-width
         if (matchOne && !pwmMode && !onePulseMode) begin
            compareOneFlag <= 1'b1;
         end else if (statusSeen && accCmp1) begin
            compareOneFlag <= 1'b0;
         end
         if (matchTwo && !pwmMode) begin
            compareTwoFlag <= 1'b1;
         end else if (statusSeen && accCmp2) begin
            compareTwoFlag <= 1'b0;
         end
         if (overflowNow) begin
            overflowFlag <= 1'b1;
         end else if (statusSeen && accCnt) begin
            overflowFlag <= 1'b0;
         end
      end
   end

   // one shared level request; halt wake is not its job
   always_comb begin
      next_irq = !globalIrqMask && (
         (timerControlOne[`CCT_C1_CAP_IE] && (captureOneFlag || captureTwoFlag)) ||
         (timerControlOne[`CCT_C1_CMP_IE] && (compareOneFlag || compareTwoFlag)) ||
         (timerControlOne[`CCT_C1_OVF_IE] && overflowFlag));
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         timerIrq <= 1'b0;
      end else begin
         timerIrq <= next_irq;
      end
   end

   // output waveforms; force bits have no effect in the special modes
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         compareOnePin <= 1'b0;
         compareTwoPin <= 1'b0;
      end else begin
         if (pwmMode) begin
            if (matchTwo) begin
               compareOnePin <= timerControlOne[`CCT_C1_LEVEL2];
            end else if (matchOne) begin
               compareOnePin <= timerControlOne[`CCT_C1_LEVEL1];
            end
         end else if (onePulseMode) begin
            if (running && edgeOne) begin
               compareOnePin <= timerControlOne[`CCT_C1_LEVEL2];
            end else if (matchOne) begin
               compareOnePin <= timerControlOne[`CCT_C1_LEVEL1];
            end
         end else begin
            if (matchOne || (wrCtrl1 && regWdata[`CCT_C1_FORCE1])) begin
               // forced writes use the level being written
               compareOnePin <= wrCtrl1 ? regWdata[`CCT_C1_LEVEL1] : timerControlOne[`CCT_C1_LEVEL1];
            end
            if (matchTwo || (wrCtrl1 && regWdata[`CCT_C1_FORCE2])) begin
               compareTwoPin <= wrCtrl1 ? regWdata[`CCT_C1_LEVEL2] : timerControlOne[`CCT_C1_LEVEL2];
            end
         end
      end
   end

   // pin enable only routes; active low, low while the timer drives
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         compareOnePinEnable <= 1'b1;
         compareTwoPinEnable <= 1'b1;
      end else begin
         compareOnePinEnable <= ~timerControlTwo[`CCT_C2_PIN1_EN];
         compareTwoPinEnable <= ~timerControlTwo[`CCT_C2_PIN2_EN] | onePulseMode | pwmMode;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         unique case (regAddr)
            `CCT_ADDR_CTRL1: regRdata <= timerControlOne;
            `CCT_ADDR_CTRL2: regRdata <= timerControlTwo;
            `CCT_ADDR_STATUS: regRdata <= {captureOneFlag, compareOneFlag, overflowFlag,
                                           captureTwoFlag, compareTwoFlag, 3'h0};
            `CCT_ADDR_CMP1_HI: regRdata <= compareOneValue[15:8];
            `CCT_ADDR_CMP1_LO: regRdata <= compareOneValue[7:0];
            `CCT_ADDR_CMP2_HI: regRdata <= compareTwoValue[15:8];
            `CCT_ADDR_CMP2_LO: regRdata <= compareTwoValue[7:0];
            `CCT_ADDR_CAP1_HI: regRdata <= captureOneValue[15:8];
            `CCT_ADDR_CAP1_LO: regRdata <= captureOneValue[7:0];
            `CCT_ADDR_CAP2_HI: regRdata <= captureTwoValue[15:8];
            `CCT_ADDR_CAP2_LO: regRdata <= captureTwoValue[7:0];
            `CCT_ADDR_CNT_HI: regRdata <= counter[15:8];
            `CCT_ADDR_CNT_LO: regRdata <= counter[7:0];
            default: regRdata <= 8'h00;
         endcase
      end else begin
         regRdata <= 8'h00;
      end
   end

   property p_ctrl_reset;
      @(posedge mclk) $rose(reset_n) |-> timerControlOne == 8'h00 && timerControlTwo == 8'h00;
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not zero after reset");

   property p_halt_freeze;
      @(posedge mclk) disable iff (!reset_n)
         pwrState == cct_pkg::CCT_HALT && !(regWrite && regAddr == `CCT_ADDR_CNT_LO) |=> $stable(counter);
   endproperty
   a_halt_freeze: assert property (p_halt_freeze) else $error("counter moved in halt");

   sequence s_halt_edge2;
      pwrState == cct_pkg::CCT_HALT && edgeTwo;
   endsequence
   property p_halt_capture;
      @(posedge mclk) disable iff (!reset_n)
         s_halt_edge2 ##[1:300] wakeNow |=> captureTwoFlag && captureTwoValue == $past(counter);
   endproperty
   a_halt_capture: assert property (p_halt_capture) else $error("armed capture lost at wake");

   property p_irq_mask;
      @(posedge mclk) disable iff (!reset_n) globalIrqMask |=> !timerIrq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("request despite mask");

   property p_irq_ovf;
      @(posedge mclk) disable iff (!reset_n)
         !globalIrqMask && overflowFlag && timerControlOne[`CCT_C1_OVF_IE] |=> timerIrq;
   endproperty
   a_irq_ovf: assert property (p_irq_ovf) else $error("overflow request missing");

   property p_irq_cap;
      @(posedge mclk) disable iff (!reset_n)
         !globalIrqMask && captureTwoFlag && timerControlOne[`CCT_C1_CAP_IE] |=> timerIrq;
   endproperty
   a_irq_cap: assert property (p_irq_cap) else $error("capture request missing");

   property p_irq_cmp_off;
      @(posedge mclk) disable iff (!reset_n)
         timerControlOne[7:5] == 3'h2 && !captureOneFlag |=>
            timerIrq == (!$past(globalIrqMask) && $past(compareOneFlag || compareTwoFlag));
   endproperty
   a_irq_cmp_off: assert property (p_irq_cmp_off) else $error("compare gating wrong");

   property p_pwm_no_cmp;
      @(posedge mclk) disable iff (!reset_n) pwmMode && !compareOneFlag |=> !compareOneFlag;
   endproperty
   a_pwm_no_cmp: assert property (p_pwm_no_cmp) else $error("compare flag in pwm mode");

   property p_force_one;
      @(posedge mclk) disable iff (!reset_n)
         wrCtrl1 && regWdata[`CCT_C1_FORCE1] && !pwmMode && !onePulseMode |=> compareOnePin == $past(regWdata[0]);
   endproperty
   a_force_one: assert property (p_force_one) else $error("forced level one not driven");
endmodule // cct_timer
`default_nettype wire

// ### cct_timer_bench.sv
// self-checking bench of the capture/compare timer, driven through its register port
`timescale 1ns/100ps
`default_nettype none
`include "cct_defines.svh"
module cct_timer_bench;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWdata = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic haltMode = 1'b0;
   logic globalIrqMask = 1'b0;
   logic captureOneInput = 1'b0;
   logic captureTwoInput = 1'b0;
   logic externalCountClockPin = 1'b0;
   logic [7:0] regRdata;
   logic timerIrq, compareOnePin, compareOnePinEnable, compareTwoPin, compareTwoPinEnable;
   logic [7:0] seen;
   logic [7:0] held;
   logic [1:0] wave;
   int divs[3] = '{4, 2, 8};
   int failures = 0;
   int checked = 0;

   always #20 mclk = ~mclk;

   cct_timer #(.HAS_EXT_PIN(1'b1)) dut (.mclk, .reset_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
      .haltMode, .globalIrqMask, .captureOneInput, .captureTwoInput, .externalCountClockPin, .timerIrq,
      .compareOnePin, .compareOnePinEnable, .compareTwoPin, .compareTwoPinEnable);

   task automatic check(input string what, input logic [15:0] expected, input logic [15:0] got);
      checked++;
      if (got !== expected) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, expected, got);
      end
   endtask

   task automatic wr(input logic [3:0] addr, input logic [7:0] data);
      @(posedge mclk);
      regWrite <= 1'b1;
      regAddr <= addr;
      regWdata <= data;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [3:0] addr, output logic [7:0] data);
      @(posedge mclk);
      regRead <= 1'b1;
      regAddr <= addr;
      @(posedge mclk);
      regRead <= 1'b0;
      #1;
      data = regRdata;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // slow toggles so the synchronised edge detectors see every transition
   task automatic toggle(input int which, input int count);
      repeat (count) begin
         repeat (4) @(posedge mclk);
         case (which)
            0: captureOneInput <= ~captureOneInput;
            1: captureTwoInput <= ~captureTwoInput;
            default: externalCountClockPin <= ~externalCountClockPin;
         endcase
      end
      repeat (4) @(posedge mclk);
   endtask

   // gap 0 means nine toggles of the external clock pin between the two samples
   task automatic span(input string what, input int gap, input logic [7:0] expected);
      logic [7:0] first;
      logic [7:0] second;
      rd(`CCT_ADDR_CNT_LO, first);
      if (gap == 0) begin
         toggle(2, 9);
      end else begin
         repeat (gap - 2) @(posedge mclk);
      end
      rd(`CCT_ADDR_CNT_LO, second);
      check(what, {8'h00, expected}, {8'h00, second - first});
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      #(40 * 20000);
      failures++;
      summarize();
   end

   initial begin
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      rd(`CCT_ADDR_CTRL1, seen);
      check("ctrl1 reset", 8'h00, seen);
      rd(`CCT_ADDR_CTRL2, seen);
      check("ctrl2 reset", 8'h00, seen);
      check("pins released", 2'h3, {compareOnePinEnable, compareTwoPinEnable});
      wr(`CCT_ADDR_CTRL1, 8'hE7);
      rd(`CCT_ADDR_CTRL1, seen);
      check("ctrl1 readback", 8'hE7, seen);
      wr(4'hE, 8'h5A);
      rd(4'hE, seen);
      check("unmapped read", 8'h00, seen);
      wr(`CCT_ADDR_CTRL1, 8'h00);
      $display("test registers done");
      for (int i = 0; i < 3; i++) begin
         wr(`CCT_ADDR_CTRL2, {4'h0, i[1:0], 2'h0});
         span("divided count", 64, 8'(64 / divs[i]));
      end
      wr(`CCT_ADDR_CTRL2, 8'h0D);
      span("rising ext count", 0, 8'h05);
      wr(`CCT_ADDR_CTRL2, 8'h0C);
      span("falling ext count", 0, 8'h05);
      $display("test clocks done");
      wr(`CCT_ADDR_CTRL2, 8'h04);
      @(posedge mclk);
      haltMode <= 1'b1;
      span("halted count", 40, 8'h00);
      @(posedge mclk);
      haltMode <= 1'b0;
      // the wake cycle does not count, so one more cycle keeps the window at 64 running edges
      span("resumed count", 65, 8'h20);
      wr(`CCT_ADDR_CTRL2, 8'h06);
      @(posedge mclk);
      haltMode <= 1'b1;
      toggle(1, 1);
      rd(`CCT_ADDR_CNT_LO, held);
      rd(`CCT_ADDR_STATUS, seen);
      check("capture held in halt", 1'b0, seen[`CCT_ST_CAP2]);
      @(posedge mclk);
      haltMode <= 1'b0;
      settle(3);
      rd(`CCT_ADDR_STATUS, seen);
      check("capture at wake", 1'b1, seen[`CCT_ST_CAP2]);
      rd(`CCT_ADDR_CAP2_LO, seen);
      check("capture wake count", held, seen);
      $display("test halt done");
      // divide by 8 keeps the next overflow far beyond the run
      wr(`CCT_ADDR_CTRL2, 8'h08);
      settle(2);
      check("request disabled", 1'b0, timerIrq);
      rd(`CCT_ADDR_STATUS, seen);
      check("overflow flag", 1'b1, seen[`CCT_ST_OVF]);
      wr(`CCT_ADDR_CTRL1, 8'h20);
      settle(2);
      check("overflow request", 1'b1, timerIrq);
      @(posedge mclk);
      globalIrqMask <= 1'b1;
      settle(2);
      check("masked request", 1'b0, timerIrq);
      @(posedge mclk);
      globalIrqMask <= 1'b0;
      rd(`CCT_ADDR_STATUS, seen);
      rd(`CCT_ADDR_CNT_LO, seen);
      settle(2);
      check("cleared request", 1'b0, timerIrq);
      $display("test overflow done");
      wr(`CCT_ADDR_CTRL1, 8'h80);
      toggle(0, 1);
      rd(`CCT_ADDR_STATUS, seen);
      check("capture on rise", 1'b0, seen[`CCT_ST_CAP1]);
      toggle(0, 1);
      rd(`CCT_ADDR_STATUS, seen);
      check("capture on fall", 1'b1, seen[`CCT_ST_CAP1]);
      check("capture request", 1'b1, timerIrq);
      wr(`CCT_ADDR_CTRL2, 8'h08);
      toggle(1, 1);
      rd(`CCT_ADDR_STATUS, seen);
      check("capture two flag", 1'b1, seen[`CCT_ST_CAP2]);
      wr(`CCT_ADDR_CTRL1, 8'h00);
      settle(2);
      check("capture inhibited", 1'b0, timerIrq);
      $display("test captures done");
      wr(`CCT_ADDR_CTRL2, 8'hC4);
      wr(`CCT_ADDR_CTRL1, 8'h1D);
      settle(1);
      check("forced high", 2'h3, {compareOnePin, compareTwoPin});
      check("pins driven", 2'h0, {compareOnePinEnable, compareTwoPinEnable});
      wr(`CCT_ADDR_CTRL1, 8'h18);
      settle(1);
      check("forced low", 2'h0, {compareOnePin, compareTwoPin});
      wr(`CCT_ADDR_CTRL1, 8'h45);
      wr(`CCT_ADDR_CNT_LO, 8'h00);
      wr(`CCT_ADDR_CMP1_HI, 8'h00);
      wr(`CCT_ADDR_CMP1_LO, 8'h10);
      wr(`CCT_ADDR_CMP2_HI, 8'h00);
      wr(`CCT_ADDR_CMP2_LO, 8'h20);
      settle(0);
      check("pin one early", 1'b0, compareOnePin);
      settle(100);
      check("match levels", 2'h3, {compareOnePin, compareTwoPin});
      check("compare request", 1'b1, timerIrq);
      $display("test compares done");
      wr(`CCT_ADDR_CTRL1, 8'h18);
      wr(`CCT_ADDR_CTRL1, 8'h06);
      wr(`CCT_ADDR_CTRL2, 8'hA8);
      settle(1);
      check("pulse idle", 1'b0, compareOnePin);
      toggle(0, 1);
      check("pulse level", 1'b1, compareOnePin);
      rd(`CCT_ADDR_CAP1_LO, seen);
      check("pulse capture", 8'hFD, seen);
      settle(200);
      check("pulse end", 1'b0, compareOnePin);
      $display("test one pulse done");
      // both mode bits set: pulse-width must win, with a full period inside the window
      wr(`CCT_ADDR_CTRL1, 8'h84);
      wr(`CCT_ADDR_CTRL2, 8'hB4);
      wr(`CCT_ADDR_CNT_LO, 8'h00);
      rd(`CCT_ADDR_STATUS, seen);
      rd(`CCT_ADDR_CMP1_LO, seen);
      rd(`CCT_ADDR_STATUS, seen);
      rd(`CCT_ADDR_CMP2_LO, seen);
      rd(`CCT_ADDR_STATUS, seen);
      rd(`CCT_ADDR_CAP1_LO, seen);
      wave = 2'h0;
      repeat (100) begin
         @(posedge mclk);
         #1;
         wave = wave | {compareOnePin, ~compareOnePin};
      end
      check("pwm waveform", 2'h3, wave);
      rd(`CCT_ADDR_STATUS, seen);
      check("pwm period flag", 1'b1, seen[`CCT_ST_CAP1]);
      check("pwm compare flags", 2'h0, {seen[`CCT_ST_CMP1], seen[`CCT_ST_CMP2]});
      $display("test pwm done");
      @(posedge mclk);
      reset_n <= 1'b0;
      settle(2);
      @(posedge mclk);
      reset_n <= 1'b1;
      rd(`CCT_ADDR_CTRL2, seen);
      check("ctrl2 after reset", 8'h00, seen);
      rd(`CCT_ADDR_CNT_HI, seen);
      check("counter restart", 8'hFF, seen);
      $display("test second reset done");
      summarize();
   end
endmodule // cct_timer_bench
`default_nettype wire
